// ---- rtl/oac_area_win.v ----
`timescale 1ns/10ps
`default_nettype none
`include "oac_defines.vh"

module oac_area_win
(
	// position counters
	input  wire [`OAC_PW-1:0] hpos,
	input  wire [`OAC_PW-1:0] vpos,
	// plane rectangle
	input  wire [`OAC_PW-1:0] hstart,
	input  wire [`OAC_PW-1:0] hend,
	input  wire [`OAC_PW-1:0] vstart,
	input  wire [`OAC_PW-1:0] vend,
	// result
	output wire               active
);

	wire h_in;
	wire v_in;

	// end position itself is outside the plane
	assign h_in   = (hpos >= hstart) && (hpos < hend);
	assign v_in   = (vpos >= vstart) && (vpos < vend);
	assign active = h_in && v_in;

endmodule // oac_area_win

`default_nettype wire

// ---- rtl/oac_defines.vh ----
// Notes on behaviour
// - two planes each hold a 9-bit horizontal start, unit two dot clocks
// - two planes each hold a 9-bit horizontal end, unit two dot clocks
// - equal char and area start: characters start eight counts later
// - two planes each hold a 9-bit vertical start, unit one line
// - two planes each hold a 9-bit vertical end, unit one line
// - twelve display lines each have a 2-bit size or off field
// - size code 11 small, 10 middle, 01 large, 00 off
// - an off line shows nothing but keeps small-line height
// - positions, sizes, fringe enables move to display on transfer request
// - normal scan with field flag clear shows even dot rows only
// - dot size doubles per size step; double scan doubles dot height
// - small cell 16 wide, 9/11/12/13 lines tall, scaled by size/scan
// - smoothing fills quarter dot at diagonal corners, never small size
// - smoothing enable acts at once, without transfer request
// - enabled fringe draws one-dot border around character dots
// - active neighbour dot beats fringe; underlines get no fringe
// - each of twelve lines has its own fringe enable
// - one 4-bit intensity/red/green/blue fringe colour for the page
// - intensity select 0 gives 15 colours, 1 drops intensity bit
// - rgb bits give black to white; intensity gives dark shades
// - no fringe left of first column or right of column 32
// - overlap priority: code, area 1, area 2, raster
`ifndef OAC_DEFINES_VH
`define OAC_DEFINES_VH

`define OAC_AW          8
`define OAC_DW          32
`define OAC_PW          9
`define OAC_LINES       12

// register byte offsets
`define OAC_A_POS_LAST  8'h1C
`define OAC_A_LSIZE     8'h20
`define OAC_A_FRLO      8'h24
`define OAC_A_FRHI      8'h28
`define OAC_A_MISC      8'h2C
`define OAC_A_COLR      8'h30
`define OAC_A_JIT       8'h34
`define OAC_A_STAT      8'h38

// field positions
`define OAC_MISC_DSCAN  7
`define OAC_MISC_ISEL   6
`define OAC_MISC_SMZ    4
`define OAC_MISC_XFER   2
`define OAC_JIT_FLD     0
`define OAC_COL_I       3

// size codes
`define OAC_SZ_SMALL    2'h3
`define OAC_SZ_MID      2'h2
`define OAC_SZ_LARGE    2'h1
`define OAC_SZ_OFF      2'h0

// cell widths in dot clocks
`define OAC_W_SMALL     8'h10
`define OAC_W_MID       8'h20
`define OAC_W_LARGE     8'h40

// cell heights in lines, normal scan: plain, fringe, underline, both
`define OAC_H_S0        8'h09
`define OAC_H_S1        8'h0B
`define OAC_H_S2        8'h0C
`define OAC_H_S3        8'h0D
`define OAC_H_M0        8'h12
`define OAC_H_M1        8'h14
`define OAC_H_M2        8'h18
`define OAC_H_M3        8'h19
`define OAC_H_L0        8'h24
`define OAC_H_L1        8'h28
`define OAC_H_L2        8'h30
`define OAC_H_L3        8'h32

`define OAC_CHAR_DLY    9'h008
`define OAC_HCNT_MAX    10'h3FF
`define OAC_VCNT_MAX    9'h1FF

// 3x3 glyph window bit positions
`define OAC_G_UL        8
`define OAC_G_U         7
`define OAC_G_UR        6
`define OAC_G_L         5
`define OAC_G_C         4
`define OAC_G_R         3
`define OAC_G_DL        2
`define OAC_G_D         1
`define OAC_G_DR        0

`endif

// ---- rtl/oac_top.v ----
// Local design decisions: the APB interface to the registers and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
`include "oac_defines.vh"

module oac_top
(
	// clock and reset
	input  wire                 pclk,
	input  wire                 presetn,
	// apb slave
	input  wire                 psel,
	input  wire                 penable,
	input  wire                 pwrite,
	input  wire [`OAC_AW-1:0]   paddr,
	input  wire [`OAC_DW-1:0]   pwdata,
	output reg  [`OAC_DW-1:0]   prdata,
	output reg                  pready,
	output reg                  pslverr,
	// sync pins
	input  wire                 hd_n,
	input  wire                 vd_n,
	// code plane side
	input  wire [3:0]           cur_line,
	input  wire [`OAC_PW-1:0]   char_hstart,
	input  wire [8:0]           glyph_win,
	input  wire                 dot_row_odd,
	input  wire [1:0]           dot_quad,
	input  wire                 underline_dot,
	input  wire                 edge_left,
	input  wire                 edge_right,
	input  wire [3:0]           char_colour,
	// other planes
	input  wire [3:0]           area1_colour,
	input  wire [3:0]           area2_colour,
	input  wire                 raster_on,
	input  wire [3:0]           raster_colour,
	// area and geometry
	output reg                  area1_active_reg,
	output reg                  area2_active_reg,
	output reg  [`OAC_PW-1:0]   char_hstart_adj_reg,
	output reg                  line_on_reg,
	output reg  [7:0]           line_width_reg,
	output reg  [7:0]           line_height_reg,
	output reg                  even_rows_only_reg,
	// pixel
	output reg                  pix_on_reg,
	output reg                  pix_fringe_reg,
	output reg  [3:0]           pix_colour_reg
);

	integer i;
	integer j;

	// settings: positions, sizes, fringe enables have a software shadow and a display copy; the rest are single
	reg [`OAC_PW-1:0] pos_sh  [0:7];
	reg [`OAC_PW-1:0] pos_act [0:7];
	reg [23:0]        lsize_sh_reg;
	reg [23:0]        lsize_act_reg;
	reg [11:0]        fren_sh_reg;
	reg [11:0]        fren_act_reg;
	reg               dscan_reg;
	reg               isel_reg;
	reg               smz_reg;
	reg               fld_reg;
	reg [3:0]         fr_colour_reg;
	reg               xfer_pend_reg;
	reg               xfer_pend_next;

	// sync and counters
	reg [1:0]         sync1_reg;
	reg [1:0]         sync2_reg;
	reg [1:0]         sync3_reg;
	reg [1:0]         filt_reg;
	reg [1:0]         filt_d_reg;
	reg [9:0]         hcnt_reg;
	reg [`OAC_PW-1:0] vcnt_reg;
	reg               half_reg;

	wire              hd_fall;
	wire              vd_fall;
	wire              setup;
	wire              wr_en;
	wire              xfer_set;
	wire [1:0]        area_act;
	reg  [`OAC_DW-1:0] rd_mux;

	function addr_ok;
		input [`OAC_AW-1:0] a;
		begin
			addr_ok = (a[1:0] == 2'h0) && (a <= `OAC_A_STAT);
		end
	endfunction

	function [7:0] cell_height;
		input [1:0] sz;
		input       ul;
		input       fr;
		input       ds;
		reg   [7:0] h;
		begin
			h = `OAC_H_S0;
			case ({sz, ul, fr})
				{`OAC_SZ_MID,   2'h0}: h = `OAC_H_M0;
				{`OAC_SZ_MID,   2'h1}: h = `OAC_H_M1;
				{`OAC_SZ_MID,   2'h2}: h = `OAC_H_M2;
				{`OAC_SZ_MID,   2'h3}: h = `OAC_H_M3;
				{`OAC_SZ_LARGE, 2'h0}: h = `OAC_H_L0;
				{`OAC_SZ_LARGE, 2'h1}: h = `OAC_H_L1;
				{`OAC_SZ_LARGE, 2'h2}: h = `OAC_H_L2;
				{`OAC_SZ_LARGE, 2'h3}: h = `OAC_H_L3;
				// small and off lines share small heights
				{`OAC_SZ_SMALL, 2'h1},
				{`OAC_SZ_OFF,   2'h1}: h = `OAC_H_S1;
				{`OAC_SZ_SMALL, 2'h2},
				{`OAC_SZ_OFF,   2'h2}: h = `OAC_H_S2;
				{`OAC_SZ_SMALL, 2'h3},
				{`OAC_SZ_OFF,   2'h3}: h = `OAC_H_S3;
				default:               h = `OAC_H_S0;
			endcase
			// double scan doubles dot height
			cell_height = ds ? {h[6:0], 1'b0} : h;
		end
	endfunction

	function [7:0] cell_width;
		input [1:0] sz;
		begin
			case (sz)
				`OAC_SZ_MID:   cell_width = `OAC_W_MID;
				`OAC_SZ_LARGE: cell_width = `OAC_W_LARGE;
				default:       cell_width = `OAC_W_SMALL;
			endcase
		end
	endfunction

	// apb handshake: zero wait, answer registered in setup cycle
	assign setup    = psel && !penable;
	assign wr_en    = psel && penable && pwrite && pready && addr_ok(paddr);
	assign xfer_set = wr_en && (paddr == `OAC_A_MISC) &&
	                  pwdata[`OAC_MISC_XFER];

	always @*
	begin
		rd_mux = {`OAC_DW{1'b0}};
		if (paddr <= `OAC_A_POS_LAST)
			rd_mux[`OAC_PW-1:0] = pos_sh[paddr[4:2]];
		else
		begin
			case (paddr)
				`OAC_A_LSIZE: rd_mux[23:0] = lsize_sh_reg;
				`OAC_A_FRLO:  rd_mux[7:0]  = fren_sh_reg[7:0];
				`OAC_A_FRHI:  rd_mux[3:0]  = fren_sh_reg[11:8];
				`OAC_A_MISC:
				begin
					rd_mux[`OAC_MISC_DSCAN] = dscan_reg;
					rd_mux[`OAC_MISC_ISEL]  = isel_reg;
					rd_mux[`OAC_MISC_SMZ]   = smz_reg;
					rd_mux[`OAC_MISC_XFER]  = xfer_pend_reg;
				end
				`OAC_A_COLR:  rd_mux[3:0]  = fr_colour_reg;
				`OAC_A_JIT:   rd_mux[`OAC_JIT_FLD] = fld_reg;
				`OAC_A_STAT:  rd_mux = {7'h00, vcnt_reg, 6'h00, hcnt_reg};
				default:      rd_mux = {`OAC_DW{1'b0}};
			endcase
		end
	end

	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prdata  <= {`OAC_DW{1'b0}};
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end
		else
		begin
			pready  <= setup;
			pslverr <= setup && !addr_ok(paddr);
			if (setup && !pwrite && addr_ok(paddr))
				prdata <= rd_mux;
			else if (setup)
				prdata <= {`OAC_DW{1'b0}};
		end
	end

	// software-side registers
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			for (i = 0; i < 8; i = i + 1)
				pos_sh[i] <= {`OAC_PW{1'b0}};
			lsize_sh_reg  <= 24'h000000;
			fren_sh_reg   <= 12'h000;
			dscan_reg     <= 1'b0;
			isel_reg      <= 1'b0;
			smz_reg       <= 1'b0;
			fld_reg       <= 1'b0;
			fr_colour_reg <= 4'h0;
		end
		else if (wr_en)
		begin
			if (paddr <= `OAC_A_POS_LAST)
				pos_sh[paddr[4:2]] <= pwdata[`OAC_PW-1:0];
			else
			begin
				case (paddr)
					`OAC_A_LSIZE: lsize_sh_reg <= pwdata[23:0];
					`OAC_A_FRLO:  fren_sh_reg[7:0]  <= pwdata[7:0];
					`OAC_A_FRHI:  fren_sh_reg[11:8] <= pwdata[3:0];
					`OAC_A_MISC:
					begin
						dscan_reg <= pwdata[`OAC_MISC_DSCAN];
						isel_reg  <= pwdata[`OAC_MISC_ISEL];
						smz_reg   <= pwdata[`OAC_MISC_SMZ];
					end
					`OAC_A_COLR:  fr_colour_reg <= pwdata[3:0];
					`OAC_A_JIT:   fld_reg <= pwdata[`OAC_JIT_FLD];
					default:      fld_reg <= fld_reg;
				endcase
			end
		end
	end

	// sync pins: three stages, level moves once stages 2 and 3 agree
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			sync1_reg  <= 2'h3;
			sync2_reg  <= 2'h3;
			sync3_reg  <= 2'h3;
			filt_reg   <= 2'h3;
			filt_d_reg <= 2'h3;
		end
		else
		begin
			sync1_reg  <= {vd_n, hd_n};
			sync2_reg  <= sync1_reg;
			sync3_reg  <= sync2_reg;
			filt_reg   <= (sync2_reg & sync3_reg) |
			              (filt_reg & (sync2_reg ^ sync3_reg));
			filt_d_reg <= filt_reg;
		end
	end

	assign hd_fall = filt_d_reg[0] && !filt_reg[0];
	assign vd_fall = filt_d_reg[1] && !filt_reg[1];

	// dot and line counters
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			hcnt_reg <= 10'h000;
			vcnt_reg <= {`OAC_PW{1'b0}};
			half_reg <= 1'b0;
		end
		else
		begin
			if (hd_fall)
				hcnt_reg <= 10'h000;
			else if (hcnt_reg != `OAC_HCNT_MAX)
				hcnt_reg <= hcnt_reg + 10'h001;
			if (vd_fall)
			begin
				vcnt_reg <= {`OAC_PW{1'b0}};
				half_reg <= 1'b0;
			end
			else if (hd_fall)
			begin
				half_reg <= !half_reg;
				// double scan counts every second line
				if ((!dscan_reg || half_reg) &&
				    (vcnt_reg != `OAC_VCNT_MAX))
					vcnt_reg <= vcnt_reg + 9'h001;
			end
		end
	end

	// transfer: request waits for a line boundary, new request wins
	always @*
	begin
		xfer_pend_next = xfer_set || (xfer_pend_reg && !hd_fall);
	end

	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			xfer_pend_reg <= 1'b0;
			for (j = 0; j < 8; j = j + 1)
				pos_act[j] <= {`OAC_PW{1'b0}};
			lsize_act_reg <= 24'h000000;
			fren_act_reg  <= 12'h000;
		end
		else
		begin
			xfer_pend_reg <= xfer_pend_next;
			if (xfer_pend_reg && hd_fall)
			begin
				for (j = 0; j < 8; j = j + 1)
					pos_act[j] <= pos_sh[j];
				lsize_act_reg <= lsize_sh_reg;
				fren_act_reg  <= fren_sh_reg;
			end
		end
	end

	// area planes
	genvar g;
	generate
		for (g = 0; g < 2; g = g + 1)
		begin : g_area
			oac_area_win u_win
			(
				.hpos   (hcnt_reg[9:1]),
				.vpos   (vcnt_reg),
				.hstart (pos_act[2*g]),
				.hend   (pos_act[2*g+1]),
				.vstart (pos_act[4+2*g]),
				.vend   (pos_act[5+2*g]),
				.active (area_act[g])
			);
		end
	endgenerate

	// current line settings
	wire       line_ok = (cur_line < `OAC_LINES);
	wire [1:0] cur_sz  = line_ok ? lsize_act_reg[{cur_line, 1'b0} +: 2]
	                             : `OAC_SZ_OFF;
	wire       cur_fr  = line_ok && fren_act_reg[cur_line];
	wire       cur_on  = (cur_sz != `OAC_SZ_OFF);
	wire       even_only = !dscan_reg && !fld_reg;
	wire [9:0] char_sum = {1'b0, char_hstart} + {1'b0, `OAC_CHAR_DLY};
	wire       char_clash = (char_hstart == pos_act[0]) ||
	                        (char_hstart == pos_act[2]);

	// pixel ornament
	wire c_vis = glyph_win[`OAC_G_C] &&
	             !(even_only && dot_row_odd);
	wire nb    = |(glyph_win & ~(9'h001 << `OAC_G_C));
	// glyph window holds no underline dots
	wire fr_hit = cur_on && cur_fr && nb && !glyph_win[`OAC_G_C] &&
	              !underline_dot && !edge_left && !edge_right;
	wire smz_ll = (dot_quad == 2'h2) && glyph_win[`OAC_G_L] &&
	              glyph_win[`OAC_G_D] && !glyph_win[`OAC_G_DL];
	wire smz_lr = (dot_quad == 2'h3) && glyph_win[`OAC_G_R] &&
	              glyph_win[`OAC_G_D] && !glyph_win[`OAC_G_DR];
	wire smz_ul = (dot_quad == 2'h0) && glyph_win[`OAC_G_L] &&
	              glyph_win[`OAC_G_U] && !glyph_win[`OAC_G_UL];
	wire smz_ur = (dot_quad == 2'h1) && glyph_win[`OAC_G_R] &&
	              glyph_win[`OAC_G_U] && !glyph_win[`OAC_G_UR];
	wire smz_hit = smz_reg && (cur_sz != `OAC_SZ_SMALL) &&
	               !glyph_win[`OAC_G_C] &&
	               (smz_ll || smz_lr || smz_ul || smz_ur);
	wire char_hit = cur_on && (c_vis || underline_dot || smz_hit);

	// intensity bit dropped in 8-colour mode
	wire [3:0] imask = isel_reg ? 4'h7 : 4'hF;

	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			area1_active_reg    <= 1'b0;
			area2_active_reg    <= 1'b0;
			char_hstart_adj_reg <= {`OAC_PW{1'b0}};
			line_on_reg         <= 1'b0;
			line_width_reg      <= `OAC_W_SMALL;
			line_height_reg     <= `OAC_H_S0;
			even_rows_only_reg  <= 1'b1;
			pix_on_reg          <= 1'b0;
			pix_fringe_reg      <= 1'b0;
			pix_colour_reg      <= 4'h0;
		end
		else
		begin
			area1_active_reg <= area_act[0];
			area2_active_reg <= area_act[1];
			char_hstart_adj_reg <= char_clash ? char_sum[`OAC_PW-1:0]
			                                  : char_hstart;
			line_on_reg      <= cur_on;
			line_width_reg   <= cell_width(cur_sz);
			// no underline enable in the map, underline height off
			line_height_reg  <= cell_height(cur_sz, 1'b0, cur_fr,
			                                dscan_reg);
			even_rows_only_reg <= even_only;
			pix_fringe_reg   <= fr_hit && !char_hit;
			pix_on_reg       <= char_hit || fr_hit || area_act[0] ||
			                    area_act[1] || raster_on;
			// colour code {i,r,g,b} goes to the output mixer, ANDed with imask
			if (char_hit)
				pix_colour_reg <= char_colour & imask;
			else if (fr_hit)
				pix_colour_reg <= fr_colour_reg & imask;
			else if (area_act[0])
				pix_colour_reg <= area1_colour & imask;
			else if (area_act[1])
				pix_colour_reg <= area2_colour & imask;
			else if (raster_on)
				pix_colour_reg <= raster_colour & imask;
			else
				pix_colour_reg <= 4'h0;
		end
	end

endmodule // oac_top

`default_nettype wire

// ---- verif/oac_assertions.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "oac_defines.vh"

module oac_chk
(
	// clock, reset and bus
	input wire logic               pclk,
	input wire logic               presetn,
	input wire logic               psel,
	input wire logic               penable,
	input wire logic [`OAC_AW-1:0] paddr,
	input wire logic               pready,
	input wire logic               pslverr,
	// code plane side
	input wire logic [`OAC_PW-1:0] char_hstart,
	input wire logic [8:0]         glyph_win,
	input wire logic               dot_row_odd,
	input wire logic               underline_dot,
	input wire logic               edge_left,
	input wire logic               edge_right,
	// outputs
	input wire logic [`OAC_PW-1:0] char_hstart_adj_reg,
	input wire logic               line_on_reg,
	input wire logic [7:0]         line_width_reg,
	input wire logic               pix_fringe_reg
);
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	a_ready_setup: assert property (psel && !penable |=> pready)
		else $error("no answer after setup");
	a_ready_single: assert property (pready |=> !pready)
		else $error("answer held too long");
	a_err_misaligned: assert property
		(psel && !penable && paddr[1:0] != 2'h0 |=> pslverr)
		else $error("misaligned access not refused");
	a_fringe_edge: assert property
		(pix_fringe_reg |-> !$past(edge_left) && !$past(edge_right))
		else $error("fringe past outer column");
	a_char_fringe: assert property
		($past(glyph_win[4]) && !$past(dot_row_odd) |-> !pix_fringe_reg)
		else $error("fringe over character dot");
	a_ul_fringe: assert property
		($past(underline_dot) |-> !pix_fringe_reg)
		else $error("underline fringed");
	a_width_legal: assert property
		(line_width_reg inside {8'h10, 8'h20, 8'h40})
		else $error("illegal cell width");
	a_off_small: assert property
		(!line_on_reg |-> line_width_reg == `OAC_W_SMALL)
		else $error("off line not small width");
	a_char_delay: assert property
		($past(presetn) && char_hstart_adj_reg != $past(char_hstart)
		|-> char_hstart_adj_reg == $past(char_hstart) + `OAC_CHAR_DLY)
		else $error("bad character start shift");
endmodule // oac_chk
`default_nettype wire

// ---- verif/oac_sync_model.sv ----
`timescale 1ns/10ps
`default_nettype none

module oac_sync_model
#(
	parameter int LINE_DOTS = 128,
	parameter int LINES     = 16
)
(
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// sync pins, active low
	output logic     hd_n,
	output logic     vd_n
);
	int dot;
	int line;

	// vertical sync falls mid-line, clear of the line sync edge
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			dot <= 0;
			line <= 0;
			hd_n <= 1'b1;
			vd_n <= 1'b1;
		end
		else
		begin
			dot <= (dot == LINE_DOTS - 1) ? 0 : dot + 1;
			if (dot == LINE_DOTS - 1)
				line <= (line == LINES - 1) ? 0 : line + 1;
			hd_n <= !(dot < 8);
			vd_n <= !(line == 0 && dot >= 64);
		end
	end
endmodule // oac_sync_model
`default_nettype wire

// ---- verif/tb_top.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "oac_defines.vh"

module tb_top;
	localparam int FRAME = 128 * 16;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [7:0] paddr = 0;
	logic [31:0] pwdata = 0, rd, misc_v = 0;
	logic err;
	wire [31:0] prdata;
	wire pready, pslverr, hd_n, vd_n, a1, a2, lon, evn, pon, pfr;
	wire [8:0] adj;
	wire [7:0] lw, lh;
	wire [3:0] pcol;
	logic [3:0] cur_line = 0;
	logic [8:0] char_hstart = 0, glyph_win = 0;
	logic dot_row_odd = 0, underline_dot = 0, edge_left = 0, edge_right = 0;
	logic [1:0] dot_quad = 0;
	logic raster_on = 0;
	logic [8:0] pv [8] = '{9'h4, 9'h14, 9'h0, 9'hA, 9'h2, 9'h6, 9'h5, 9'h8};
	logic [7:0] ew [4] = '{8'h10, 8'h40, 8'h20, 8'h10};
	logic [7:0] eh [4] = '{8'h09, 8'h24, 8'h12, 8'h09};
	int n_fail = 0, samples_checked = 0, n1, n2, n3;

	always #4 pclk = ~pclk;

	oac_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .hd_n(hd_n),
		.vd_n(vd_n), .cur_line(cur_line), .char_hstart(char_hstart),
		.glyph_win(glyph_win), .dot_row_odd(dot_row_odd),
		.dot_quad(dot_quad), .underline_dot(underline_dot),
		.edge_left(edge_left), .edge_right(edge_right),
		.char_colour(4'h5), .area1_colour(4'h1), .area2_colour(4'h2),
		.raster_on(raster_on), .raster_colour(4'h6), .area1_active_reg(a1),
		.area2_active_reg(a2), .char_hstart_adj_reg(adj),
		.line_on_reg(lon), .line_width_reg(lw), .line_height_reg(lh),
		.even_rows_only_reg(evn), .pix_on_reg(pon),
		.pix_fringe_reg(pfr), .pix_colour_reg(pcol));

	oac_sync_model sync_u (.pclk(pclk), .presetn(presetn), .hd_n(hd_n),
		.vd_n(vd_n));

	task chk(input string nm, input logic [31:0] seen, exp);
		samples_checked++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		n = 0;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (pready !== 1'b1 && n < 50);
		chk("pready", pready, 1);
		rd = prdata;
		err = pslverr;
		psel <= 0;
		penable <= 0;
	endtask

	task settle;
		repeat (3) @(posedge pclk);
	endtask

	// request transfer and poll the pending flag until it clears
	task xfer;
		int n;
		bus(1, `OAC_A_MISC, misc_v | 32'h4);
		n = 0;
		do
		begin
			bus(0, `OAC_A_MISC, 0);
			n++;
		end
		while (rd[2] !== 1'b0 && n < 100);
		chk("xfer_done", rd[2], 0);
		settle;
	endtask

	task count;
		n1 = 0;
		n2 = 0;
		n3 = 0;
		repeat (FRAME)
		begin
			@(posedge pclk);
			n1 += (a1 === 1'b1);
			n2 += (a2 === 1'b1);
			n3 += (pcol === 4'h2);
		end
	endtask

	task pix(input logic [8:0] g, input logic ul, input logic [1:0] ed,
		input logic [2:0] m, input logic on, fr, input logic [3:0] col);
		glyph_win <= g;
		underline_dot <= ul;
		{edge_right, edge_left} <= ed;
		settle;
		if (m[2]) chk("pix_on", pon, on);
		if (m[1]) chk("pix_fringe", pfr, fr);
		if (m[0]) chk("pix_colour", pcol, col);
	endtask

	task summarize;
		$display("checked %0d mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	initial
	begin
		#(8 * 20000);
		n_fail++;
		summarize;
	end

	initial
	begin
		repeat (16) @(posedge pclk);
		presetn <= 1;
		@(posedge pclk);
		chk("even_rows", evn, 1);
		for (int i = 0; i < 8; i++)
		begin
			bus(1, 8'(i * 4), 32'hFFFF_FFFF);
			bus(0, 8'(i * 4), 0);
			chk("pos_reg", rd, 32'h0000_01FF);
			bus(1, 8'(i * 4), 32'(pv[i]));
		end
		bus(0, 8'h3C, 0);
		chk("unmapped_err", err, 1);
		chk("unmapped_data", rd, 0);
		bus(1, 8'h02, 32'h1);
		chk("misaligned_err", err, 1);
		$display("register test done");
		count;
		chk("area1_early", n1, 0);
		xfer;
		count;
		chk("area1_dots", n1, 128);
		chk("area2_dots", n2, 60);
		chk("area2_colour_dots", n3, 48);
		$display("area test done");
		char_hstart <= 9'h4;
		settle;
		chk("char_adj_eq", adj, 9'hC);
		char_hstart <= 9'h5;
		settle;
		chk("char_adj_ne", adj, 9'h5);
		for (int c = 3; c >= 0; c--)
		begin
			bus(1, `OAC_A_LSIZE, 32'(c));
			xfer;
			chk("line_on", lon, c != 0);
			chk("line_width", lw, ew[c]);
			chk("line_height", lh, eh[c]);
		end
		bus(1, `OAC_A_LSIZE, 32'h3);
		settle;
		chk("size_held", lon, 0);
		xfer;
		misc_v = 32'h80;
		bus(1, `OAC_A_MISC, misc_v);
		settle;
		chk("dscan_height", lh, 8'h12);
		chk("dscan_rows", evn, 0);
		misc_v = 0;
		bus(1, `OAC_A_MISC, misc_v);
		bus(1, `OAC_A_JIT, 32'h1);
		settle;
		chk("field_rows", evn, 0);
		bus(1, `OAC_A_JIT, 32'h0);
		bus(1, 8'h04, 0);
		bus(1, 8'h0C, 0);
		bus(1, `OAC_A_FRLO, 32'h1);
		xfer;
		chk("fringe_height", lh, 8'h0B);
		$display("line test done");
		bus(1, `OAC_A_COLR, 32'hB);
		pix(9'h020, 0, 2'h0, 3'h7, 1, 1, 4'hB);
		misc_v = 32'h40;
		bus(1, `OAC_A_MISC, misc_v);
		pix(9'h020, 0, 2'h0, 3'h1, 0, 1, 4'h3);
		misc_v = 0;
		bus(1, `OAC_A_MISC, misc_v);
		pix(9'h020, 0, 2'h1, 3'h2, 0, 0, 0);
		pix(9'h008, 0, 2'h2, 3'h2, 0, 0, 0);
		pix(9'h010, 0, 2'h0, 3'h7, 1, 0, 4'h5);
		pix(9'h030, 0, 2'h0, 3'h6, 1, 0, 0);
		pix(9'h000, 1, 2'h0, 3'h6, 1, 0, 0);
		dot_row_odd <= 1;
		pix(9'h010, 0, 2'h0, 3'h4, 0, 0, 0);
		dot_row_odd <= 0;
		raster_on <= 1;
		pix(9'h000, 0, 2'h0, 3'h5, 1, 0, 4'h6);
		pix(9'h020, 0, 2'h0, 3'h1, 1, 1, 4'hB);
		raster_on <= 0;
		bus(1, `OAC_A_FRLO, 32'h0);
		bus(1, `OAC_A_LSIZE, 32'h2);
		xfer;
		misc_v = 32'h10;
		bus(1, `OAC_A_MISC, misc_v);
		dot_quad <= 2'b10;
		pix(9'h022, 0, 2'h0, 3'h4, 1, 0, 0);
		dot_quad <= 2'b01;
		pix(9'h022, 0, 2'h0, 3'h4, 0, 0, 0);
		bus(1, `OAC_A_LSIZE, 32'h3);
		xfer;
		dot_quad <= 2'b10;
		pix(9'h022, 0, 2'h0, 3'h4, 0, 0, 0);
		$display("pixel test done");
		summarize;
	end
endmodule // tb_top

bind oac_top oac_chk chk_u (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .paddr(paddr), .pready(pready), .pslverr(pslverr),
	.char_hstart(char_hstart), .glyph_win(glyph_win),
	.dot_row_odd(dot_row_odd), .underline_dot(underline_dot),
	.edge_left(edge_left), .edge_right(edge_right),
	.char_hstart_adj_reg(char_hstart_adj_reg), .line_on_reg(line_on_reg),
	.line_width_reg(line_width_reg), .pix_fringe_reg(pix_fringe_reg));
`default_nettype wire
